//--- inc/itfd_pkg.sv
// Purpose: Shared constants for the input terminal function decoder.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Function codes are the values held in each terminal selector.
package itfd_pkg;

  localparam int          NUM_TERMS = 6;
  localparam int          ADDR_W    = 8;
  localparam int          CNT_W     = 32;
  localparam int          RATE_W    = 16;

  // Register byte addresses.
  localparam logic [7:0]  ADDR_FAST_TYPE   = 8'h00;
  localparam logic [7:0]  ADDR_FUNC_SW1    = 8'h04;
  localparam logic [7:0]  ADDR_FUNC_SW2    = 8'h08;
  localparam logic [7:0]  ADDR_FUNC_SW3    = 8'h0C;
  localparam logic [7:0]  ADDR_FUNC_SW4    = 8'h10;
  localparam logic [7:0]  ADDR_FUNC_FAST_A = 8'h14;
  localparam logic [7:0]  ADDR_FUNC_FAST_B = 8'h18;
  localparam logic [7:0]  ADDR_RESERVED    = 8'h1C;
  localparam logic [7:0]  ADDR_POLARITY    = 8'h20;
  localparam logic [7:0]  ADDR_CONFIG      = 8'h24;
  localparam logic [7:0]  ADDR_STATUS      = 8'h28;
  localparam logic [7:0]  ADDR_ENERGY      = 8'h2C;
  localparam logic [7:0]  ADDR_POSITION    = 8'h30;
  localparam logic [7:0]  ADDR_PULSE_RATE  = 8'h34;
  localparam logic [7:0]  ADDR_EDECEL      = 8'h38;
  localparam logic [7:0]  ADDR_BASE_FUNCS  = 8'h3C;

  // Terminal indices.
  localparam int          TERM_FAST_A = 4;
  localparam int          TERM_FAST_B = 5;

  // Reset values.
  localparam logic [7:0]  RST_FAST_TYPE = 8'h00;
  localparam logic [7:0]  RST_FUNC_SW1  = 8'h01;
  localparam logic [7:0]  RST_FUNC_SW2  = 8'h04;
  localparam logic [7:0]  RST_FUNC_SW3  = 8'h07;
  localparam logic [7:0]  RST_FUNC_OTHER = 8'h00;
  localparam logic [5:0]  RST_POLARITY  = 6'h00;

  // Fast input type digits: ones digit for input A, tens digit for input B.
  localparam int          FAST_A_LSB     = 0;
  localparam int          FAST_B_LSB     = 4;
  localparam logic [3:0]  FAST_DIGITAL   = 4'h1;

  // Config register fields.
  localparam int          CFG_SRC_LSB = 0;
  localparam int          CFG_PID_BIT = 2;

  // Function codes.
  localparam logic [7:0]  FC_BASE_LAST   = 8'h0F;
  localparam logic [7:0]  FC_DC_BRAKE    = 8'h22;
  localparam logic [7:0]  FC_ALT_MOTOR   = 8'h23;
  localparam logic [7:0]  FC_SRC_KEYPAD  = 8'h24;
  localparam logic [7:0]  FC_SRC_TERM    = 8'h25;
  localparam logic [7:0]  FC_SRC_COMM    = 8'h26;
  localparam logic [7:0]  FC_PRE_EXCITE  = 8'h27;
  localparam logic [7:0]  FC_ENERGY_CLR  = 8'h28;
  localparam logic [7:0]  FC_ENERGY_HOLD = 8'h29;
  localparam logic [7:0]  FC_TORQUE_KP   = 8'h2A;
  localparam logic [7:0]  FC_ESTOP       = 8'h38;
  localparam logic [7:0]  FC_OVERTEMP    = 8'h39;
  localparam logic [7:0]  FC_TO_VF       = 8'h3B;
  localparam logic [7:0]  FC_TO_VECTOR   = 8'h3C;
  localparam logic [7:0]  FC_PID_INVERT  = 8'h3D;
  localparam logic [7:0]  FC_POS_CLR     = 8'h42;
  localparam logic [7:0]  FC_PULSE_INC   = 8'h43;
  localparam logic [7:0]  FC_SUPERIMPOSE = 8'h44;
  localparam logic [7:0]  FC_PULSE_DEC   = 8'h45;
  localparam logic [7:0]  FC_GEAR_SECOND = 8'h46;

  // Run-command sources.
  localparam logic [1:0]  SRC_KEYPAD   = 2'h0;
  localparam logic [1:0]  SRC_TERMINAL = 2'h1;
  localparam logic [1:0]  SRC_COMM     = 2'h2;

  // Control methods.
  localparam logic        CTRL_VF     = 1'b0;
  localparam logic        CTRL_VECTOR = 1'b1;

endpackage

//--- logic/itfd_decoder.sv
// Purpose: Decodes the six input terminals into drive control actions.
// Assumes: Terminal inputs are synchronous to ref_clk and already filtered.
// Notes:   Registers are reached over APB with no wait states in any transfer.
//
// Overview of operation
// - Function 34 starts DC braking immediately.
// - Function 35 selects the alternate motor.
// - Function 36 forces keypad run source.
// - Function 37 forces terminal run source.
// - Function 38 forces communication run source.
// - Function 39 pre-excites while active.
// - Function 40 activation clears energy total.
// - Function 41 freezes energy total.
// - Function 42 takes torque limit from keypad.
// - Function 56 requests emergency deceleration stop.
// - Function 57 raises motor over-temperature fault.
// - Function 59 selects V/F when stopped.
// - Function 60 selects vector when stopped.
// - Function 61 inverts configured PID polarity.
// - Function 66 activation clears position counter.
// - Function 67 adds pulses at adjust rate while function 68 is active.
// - Function 69 subtracts pulses at adjust rate while function 68 is active.
// - Function 70 selects second gear numerator.
// - Fast type digits choose pulse or digital.
// - Codes 1 to 15 decoded as base functions.
// - Selector reset defaults 1,4,7,0,0,0.
// - Six polarity bits, reset zero, invert inputs.
`timescale 1ns/10ps
`default_nettype none

module itfd_decoder (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [itfd_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [itfd_pkg::NUM_TERMS-1:0] terminal_in,
  input  wire logic                          drive_stopped,
  input  wire logic                          energy_tick,
  input  wire logic                          position_step,
  input  wire logic                          position_down,
  output logic                               dc_brake,
  output logic                               alt_motor_select,
  output logic      [1:0]                    run_source,
  output logic                               pre_excite,
  output logic                               torque_limit_keypad,
  output logic                               emergency_stop,
  output logic      [15:0]                   emergency_decel_time,
  output logic                               over_temp_fault,
  output logic                               control_mode,
  output logic                               pid_output_invert,
  output logic                               pulse_add,
  output logic                               pulse_sub,
  output logic                               second_gear_numerator,
  output logic                               fast_input_a_pulse_mode,
  output logic                               fast_input_b_pulse_mode,
  output logic      [15:0]                   base_function_active
);

  typedef struct packed {
    logic [7:0]                                     fast_type;
    logic [itfd_pkg::NUM_TERMS-1:0][7:0]            func;
    logic [itfd_pkg::NUM_TERMS-1:0]                 polarity;
    logic [1:0]                                     src_cfg;
    logic                                           pid_cfg;
    logic [itfd_pkg::RATE_W-1:0]                    pulse_rate;
    logic [15:0]                                    edecel;
    logic                                           dc_brake;
    logic                                           alt_motor;
    logic [1:0]                                     run_source;
    logic                                           pre_excite;
    logic                                           torque_kp;
    logic                                           estop;
    logic                                           overtemp;
    logic                                           control_mode;
    logic                                           pid_invert;
    logic                                           gear_second;
    logic                                           superimpose;
    logic                                           pulse_add;
    logic                                           pulse_sub;
    logic [15:0]                                    base_active;
    logic [itfd_pkg::NUM_TERMS-1:0]                 term_seen;
    logic                                           energy_clr_prev;
    logic                                           pos_clr_prev;
    logic [itfd_pkg::CNT_W-1:0]                     energy;
    logic [itfd_pkg::CNT_W-1:0]                     position;
    logic [itfd_pkg::RATE_W-1:0]                    rate_cnt;
    logic [31:0]                                    prdata;
    logic                                           pready;
    logic                                           pslverr;
  } itfd_state_t;

  itfd_state_t                     st;
  itfd_state_t                     next_st;
  logic [itfd_pkg::NUM_TERMS-1:0]  term_active;
  logic [255:0]                    code_act;
  logic                            setup_phase;
  logic                            write_commit;
  logic [31:0]                     read_value;
  logic                            addr_ok;
  logic [31:0]                     status_word;

  // A fast input in pulse mode is masked off here and never acts as a switch.
  generate
    for (genvar t = 0; t < itfd_pkg::NUM_TERMS; t++) begin : g_term
      logic digital_ok;
      if (t == itfd_pkg::TERM_FAST_A) begin : g_fa
        assign digital_ok = (st.fast_type[itfd_pkg::FAST_A_LSB +: 4] == itfd_pkg::FAST_DIGITAL);
      end else if (t == itfd_pkg::TERM_FAST_B) begin : g_fb
        assign digital_ok = (st.fast_type[itfd_pkg::FAST_B_LSB +: 4] == itfd_pkg::FAST_DIGITAL);
      end else begin : g_sw
        assign digital_ok = 1'b1;
      end
      assign term_active[t] = (terminal_in[t] ^ st.polarity[t]) & digital_ok;
    end
  endgenerate

  // Unused and reserved codes land in bits that nothing reads.
  always_comb begin
    code_act = '0;
    for (int i = 0; i < itfd_pkg::NUM_TERMS; i++) begin
      if (term_active[i]) begin
        code_act[st.func[i]] = 1'b1;
      end
    end
  end

  assign setup_phase  = psel && !penable;
  assign write_commit = psel && penable && st.pready && pwrite;

  assign status_word = {14'h0000, st.term_seen, st.superimpose, st.gear_second, st.pid_invert,
                        st.control_mode, st.overtemp, st.estop, st.torque_kp, st.pre_excite,
                        st.run_source, st.alt_motor, st.dc_brake};

  always_comb begin
    read_value = 32'h0000_0000;
    addr_ok    = 1'b1;
    case (paddr)
      itfd_pkg::ADDR_FAST_TYPE:   read_value = {24'h000000, st.fast_type};
      itfd_pkg::ADDR_FUNC_SW1:    read_value = {24'h000000, st.func[0]};
      itfd_pkg::ADDR_FUNC_SW2:    read_value = {24'h000000, st.func[1]};
      itfd_pkg::ADDR_FUNC_SW3:    read_value = {24'h000000, st.func[2]};
      itfd_pkg::ADDR_FUNC_SW4:    read_value = {24'h000000, st.func[3]};
      itfd_pkg::ADDR_FUNC_FAST_A: read_value = {24'h000000, st.func[4]};
      itfd_pkg::ADDR_FUNC_FAST_B: read_value = {24'h000000, st.func[5]};
      itfd_pkg::ADDR_RESERVED:    read_value = 32'h0000_0000;
      itfd_pkg::ADDR_POLARITY:    read_value = {26'h0000000, st.polarity};
      itfd_pkg::ADDR_CONFIG:      read_value = {29'h00000000, st.pid_cfg, st.src_cfg};
      itfd_pkg::ADDR_STATUS:      read_value = status_word;
      itfd_pkg::ADDR_ENERGY:      read_value = st.energy;
      itfd_pkg::ADDR_POSITION:    read_value = st.position;
      itfd_pkg::ADDR_PULSE_RATE:  read_value = {16'h0000, st.pulse_rate};
      itfd_pkg::ADDR_EDECEL:      read_value = {16'h0000, st.edecel};
      itfd_pkg::ADDR_BASE_FUNCS:  read_value = {16'h0000, st.base_active};
      default:                    addr_ok    = 1'b0;
    endcase
  end

  always_comb begin
    logic energy_clr;
    logic pos_clr;
    logic adj_req;
    logic fire;
    energy_clr = 1'b0;
    pos_clr    = 1'b0;
    adj_req    = 1'b0;
    fire       = 1'b0;
    next_st    = st;

    // APB: no wait states; data and error are captured in the setup cycle.
    next_st.pready  = setup_phase;
    next_st.pslverr = setup_phase && !addr_ok;
    if (setup_phase) begin
      next_st.prdata = read_value;
    end
    if (write_commit && addr_ok) begin
      case (paddr)
        itfd_pkg::ADDR_FAST_TYPE:   next_st.fast_type = pwdata[7:0];
        itfd_pkg::ADDR_FUNC_SW1:    next_st.func[0] = pwdata[7:0];
        itfd_pkg::ADDR_FUNC_SW2:    next_st.func[1] = pwdata[7:0];
        itfd_pkg::ADDR_FUNC_SW3:    next_st.func[2] = pwdata[7:0];
        itfd_pkg::ADDR_FUNC_SW4:    next_st.func[3] = pwdata[7:0];
        itfd_pkg::ADDR_FUNC_FAST_A: next_st.func[4] = pwdata[7:0];
        itfd_pkg::ADDR_FUNC_FAST_B: next_st.func[5] = pwdata[7:0];
        itfd_pkg::ADDR_POLARITY:    next_st.polarity = pwdata[itfd_pkg::NUM_TERMS-1:0];
        itfd_pkg::ADDR_CONFIG: begin
          next_st.src_cfg = pwdata[itfd_pkg::CFG_SRC_LSB +: 2];
          next_st.pid_cfg = pwdata[itfd_pkg::CFG_PID_BIT];
        end
        itfd_pkg::ADDR_PULSE_RATE:  next_st.pulse_rate = pwdata[itfd_pkg::RATE_W-1:0];
        itfd_pkg::ADDR_EDECEL:      next_st.edecel = pwdata[15:0];
        default: begin
        end
      endcase
    end

    next_st.term_seen   = term_active;
    next_st.base_active = {code_act[itfd_pkg::FC_BASE_LAST:1], 1'b0};
    next_st.dc_brake    = code_act[itfd_pkg::FC_DC_BRAKE];
    next_st.alt_motor   = code_act[itfd_pkg::FC_ALT_MOTOR];
    next_st.pre_excite  = code_act[itfd_pkg::FC_PRE_EXCITE];
    next_st.torque_kp   = code_act[itfd_pkg::FC_TORQUE_KP];
    next_st.estop       = code_act[itfd_pkg::FC_ESTOP];
    next_st.overtemp    = code_act[itfd_pkg::FC_OVERTEMP];
    next_st.pid_invert  = st.pid_cfg ^ code_act[itfd_pkg::FC_PID_INVERT];
    next_st.gear_second = code_act[itfd_pkg::FC_GEAR_SECOND];
    next_st.superimpose = code_act[itfd_pkg::FC_SUPERIMPOSE];

    // Keypad outranks terminal, which outranks communication.
    if (code_act[itfd_pkg::FC_SRC_KEYPAD]) begin
      next_st.run_source = itfd_pkg::SRC_KEYPAD;
    end else if (code_act[itfd_pkg::FC_SRC_TERM]) begin
      next_st.run_source = itfd_pkg::SRC_TERMINAL;
    end else if (code_act[itfd_pkg::FC_SRC_COMM]) begin
      next_st.run_source = itfd_pkg::SRC_COMM;
    end else begin
      next_st.run_source = st.src_cfg;
    end

    // The control method only changes while the drive is at rest; V/F wins a tie.
    if (drive_stopped && code_act[itfd_pkg::FC_TO_VF]) begin
      next_st.control_mode = itfd_pkg::CTRL_VF;
    end else if (drive_stopped && code_act[itfd_pkg::FC_TO_VECTOR]) begin
      next_st.control_mode = itfd_pkg::CTRL_VECTOR;
    end

    energy_clr = code_act[itfd_pkg::FC_ENERGY_CLR] && !st.energy_clr_prev;
    next_st.energy_clr_prev = code_act[itfd_pkg::FC_ENERGY_CLR];
    if (energy_clr) begin
      next_st.energy = '0;
    end else if (energy_tick && !code_act[itfd_pkg::FC_ENERGY_HOLD]) begin
      next_st.energy = st.energy + 1'b1;
    end

    pos_clr = code_act[itfd_pkg::FC_POS_CLR] && !st.pos_clr_prev;
    next_st.pos_clr_prev = code_act[itfd_pkg::FC_POS_CLR];
    if (pos_clr) begin
      next_st.position = '0;
    end else if (position_step) begin
      next_st.position = position_down ? st.position - 1'b1 : st.position + 1'b1;
    end

    // Increase and decrease together cancel; a rate of zero gives no pulses.
    adj_req = code_act[itfd_pkg::FC_SUPERIMPOSE] &&
              (code_act[itfd_pkg::FC_PULSE_INC] ^ code_act[itfd_pkg::FC_PULSE_DEC]);
    if (adj_req && (st.pulse_rate != '0)) begin
      fire = (st.rate_cnt >= st.pulse_rate - 1'b1);
      next_st.rate_cnt = fire ? '0 : st.rate_cnt + 1'b1;
    end else begin
      next_st.rate_cnt = '0;
    end
    next_st.pulse_add = fire && code_act[itfd_pkg::FC_PULSE_INC];
    next_st.pulse_sub = fire && code_act[itfd_pkg::FC_PULSE_DEC];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st           <= '0;
      st.fast_type <= itfd_pkg::RST_FAST_TYPE;
      st.func[0]   <= itfd_pkg::RST_FUNC_SW1;
      st.func[1]   <= itfd_pkg::RST_FUNC_SW2;
      st.func[2]   <= itfd_pkg::RST_FUNC_SW3;
      st.func[3]   <= itfd_pkg::RST_FUNC_OTHER;
      st.func[4]   <= itfd_pkg::RST_FUNC_OTHER;
      st.func[5]   <= itfd_pkg::RST_FUNC_OTHER;
      st.polarity  <= itfd_pkg::RST_POLARITY;
      st.run_source <= itfd_pkg::SRC_KEYPAD;
      st.control_mode <= itfd_pkg::CTRL_VF;
    end else begin
      st <= next_st;
    end
  end

  assign prdata                  = st.prdata;
  assign pready                  = st.pready;
  assign pslverr                 = st.pslverr;
  assign dc_brake                = st.dc_brake;
  assign alt_motor_select        = st.alt_motor;
  assign run_source              = st.run_source;
  assign pre_excite              = st.pre_excite;
  assign torque_limit_keypad     = st.torque_kp;
  assign emergency_stop          = st.estop;
  assign emergency_decel_time    = st.edecel;
  assign over_temp_fault         = st.overtemp;
  assign control_mode            = st.control_mode;
  assign pid_output_invert       = st.pid_invert;
  assign pulse_add               = st.pulse_add;
  assign pulse_sub               = st.pulse_sub;
  assign second_gear_numerator   = st.gear_second;
  assign fast_input_a_pulse_mode = (st.fast_type[itfd_pkg::FAST_A_LSB +: 4] != itfd_pkg::FAST_DIGITAL);
  assign fast_input_b_pulse_mode = (st.fast_type[itfd_pkg::FAST_B_LSB +: 4] != itfd_pkg::FAST_DIGITAL);
  assign base_function_active    = st.base_active;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_dc_brake_start:   assert property (code_act[itfd_pkg::FC_DC_BRAKE] |=> dc_brake)
    else $error("DC brake did not start one cycle after activation.");
  a_alt_motor_sel:    assert property (code_act[itfd_pkg::FC_ALT_MOTOR] != $past(code_act[itfd_pkg::FC_ALT_MOTOR])
                                       |=> alt_motor_select == $past(code_act[itfd_pkg::FC_ALT_MOTOR], 1))
    else $error("Alternate motor select did not follow its terminal.");
  a_src_keypad:       assert property (code_act[itfd_pkg::FC_SRC_KEYPAD] |=> run_source == itfd_pkg::SRC_KEYPAD)
    else $error("Run source not forced to keypad.");
  a_src_terminal:     assert property (code_act[itfd_pkg::FC_SRC_TERM] && !code_act[itfd_pkg::FC_SRC_KEYPAD]
                                       |=> run_source == itfd_pkg::SRC_TERMINAL)
    else $error("Run source not forced to terminals.");
  a_src_comm:         assert property (code_act[itfd_pkg::FC_SRC_COMM] && !code_act[itfd_pkg::FC_SRC_TERM]
                                       && !code_act[itfd_pkg::FC_SRC_KEYPAD] |=> run_source == itfd_pkg::SRC_COMM)
    else $error("Run source not forced to communication.");
  a_pre_excite_end:   assert property ($fell(code_act[itfd_pkg::FC_PRE_EXCITE]) |=> !pre_excite)
    else $error("Pre-excitation did not end with its terminal.");
  a_energy_clear:     assert property ($rose(code_act[itfd_pkg::FC_ENERGY_CLR]) |=> st.energy == '0)
    else $error("Energy total not cleared on activation.");
  a_energy_hold:      assert property (code_act[itfd_pkg::FC_ENERGY_HOLD] && !$rose(code_act[itfd_pkg::FC_ENERGY_CLR])
                                       |=> $stable(st.energy))
    else $error("Energy total changed while held.");
  a_mode_running:     assert property (!drive_stopped |=> $stable(control_mode))
    else $error("Control method changed while running.");
  a_mode_vector:      assert property (drive_stopped && code_act[itfd_pkg::FC_TO_VECTOR] && !code_act[itfd_pkg::FC_TO_VF]
                                       |=> control_mode == itfd_pkg::CTRL_VECTOR)
    else $error("Stopped drive did not switch to vector control.");
  a_pos_clear:        assert property ($rose(code_act[itfd_pkg::FC_POS_CLR]) |=> st.position == '0)
    else $error("Position counter not cleared on activation.");
  a_pulse_gate:       assert property (!code_act[itfd_pkg::FC_SUPERIMPOSE] |=> !pulse_add && !pulse_sub)
    else $error("Pulse adjust active without superimposition.");
  a_apb_answer:       assert property (setup_phase |=> pready ##1 !pready)
    else $error("APB answer not given in the access cycle.");

  c_dc_brake:         cover property ($rose(dc_brake));
  c_src_restore:      cover property (run_source == itfd_pkg::SRC_COMM ##1 run_source == st.src_cfg);
  c_pulse_add:        cover property (pulse_add);
  c_bad_address:      cover property (pready && pslverr);

endmodule

`default_nettype wire

//--- dv/itfd_contact_model.sv
// Purpose: Stand-in for the switch contacts on the six terminals.
// Assumes: Contacts are debounced and synchronous to ref_clk.
// Notes:   A requested level reaches the terminal one edge later.
`timescale 1ns/10ps
`default_nettype none
module itfd_contact_model (
  input  wire logic       ref_clk,
  input  wire logic [5:0] want,
  output logic      [5:0] terminal_in
);
  always_ff @(posedge ref_clk) begin
    terminal_in <= want;
  end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Purpose: Self-checking bench for the terminal function decoder.
// Assumes: One APB transfer at a time; terminals go through the contact model.
// Notes:   Each scenario drives the block and judges the outputs itself.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic        drive_stopped = 1, energy_tick = 0, position_step = 0;
  logic [7:0]  paddr = 8'h00;
  logic [5:0]  want = 6'h00, terminal_in;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, dc_brake, alt_motor_select, pre_excite, torque_limit_keypad;
  logic        emergency_stop, over_temp_fault, control_mode, pid_output_invert, second_gear_numerator;
  logic [1:0]  run_source;
  logic        pulse_add, pulse_sub;
  logic [15:0] edt;
  logic [7:0]  lv;
  int          n_errors = 0, n_checks = 0;
  assign lv = {dc_brake, alt_motor_select, pre_excite, torque_limit_keypad,
               emergency_stop, over_temp_fault, pid_output_invert, second_gear_numerator};
  always #12.5 ref_clk = ~ref_clk;
  itfd_contact_model itfd_contact_model_inst (.ref_clk(ref_clk), .want(want), .terminal_in(terminal_in));
  itfd_decoder itfd_decoder_inst (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .terminal_in(terminal_in), .drive_stopped(drive_stopped), .energy_tick(energy_tick),
    .position_step(position_step), .position_down(1'b0), .dc_brake(dc_brake),
    .alt_motor_select(alt_motor_select), .run_source(run_source), .pre_excite(pre_excite),
    .torque_limit_keypad(torque_limit_keypad), .emergency_stop(emergency_stop), .emergency_decel_time(edt),
    .over_temp_fault(over_temp_fault), .control_mode(control_mode), .pid_output_invert(pid_output_invert),
    .pulse_add(pulse_add), .pulse_sub(pulse_sub), .second_gear_numerator(second_gear_numerator),
    .fast_input_a_pulse_mode(), .fast_input_b_pulse_mode(), .base_function_active());
  task stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk) penable <= 1'b1;
    k = 0;
    do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin n_errors++; stop_test(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Counts adjust pulses over twenty cycles.
  task count_pulses(output int na, output int ns);
    na = 0; ns = 0;
    repeat (20) begin @(posedge ref_clk); na += pulse_add; ns += pulse_sub; end
  endtask
  task t_pulse;
    int na, ns;
    apb(1, 8'h38, 32'h1234); check("edecel", {16'h0, edt}, 32'h1234);
    apb(1, 8'h34, 32'h4); apb(1, 8'h04, 32'h44); apb(1, 8'h08, 32'h43); apb(1, 8'h0C, 32'h45);
    term(6'h02); count_pulses(na, ns); check("pulse_gated", na + ns, 0);
    term(6'h03); count_pulses(na, ns); check("pulse_add", na, 5);
    check("pulse_add_only", ns, 0);
    term(6'h05); count_pulses(na, ns); check("pulse_sub", ns, 5);
    check("pulse_sub_only", na, 0);
    term(6'h07); count_pulses(na, ns); check("pulse_cancel", na + ns, 0);
    term(6'h00);
  endtask
  task term(input logic [5:0] v);
    want <= v;
    repeat (3) @(posedge ref_clk);
  endtask
  task t_reset;
    logic [7:0] rv [7] = '{8'h00, 8'h01, 8'h04, 8'h07, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      apb(0, 8'(i * 4), 0); check("sel_reset", rd, {24'h0, rv[i]});
    end
    apb(0, 8'h20, 0); check("pol_reset", rd, 32'h0);
    apb(1, 8'hFC, 32'h5); check("unmapped_err", {31'h0, err}, 32'h1);
  endtask
  task t_levels;
    logic [7:0] c [9] = '{8'h22, 8'h23, 8'h27, 8'h2A, 8'h38, 8'h39, 8'h3D, 8'h46, 8'h47};
    for (int i = 0; i < 9; i++) begin
      apb(1, 8'h04, {24'h0, c[i]}); term(6'h01);
      check("level_on", {24'h0, lv}, 32'h80 >> i);
      term(6'h00); check("level_off", {24'h0, lv}, 32'h0);
    end
  endtask
  task t_source;
    logic [1:0] cf [3] = '{2'h1, 2'h0, 2'h0};
    logic [1:0] ex [3] = '{2'h0, 2'h1, 2'h2};
    for (int i = 0; i < 3; i++) begin
      apb(1, 8'h24, {30'h0, cf[i]}); apb(1, 8'h04, 32'h24 + i); term(6'h01);
      check("src_forced", {30'h0, run_source}, {30'h0, ex[i]});
      term(6'h00); check("src_back", {30'h0, run_source}, {30'h0, cf[i]});
    end
  endtask
  task t_counts;
    apb(1, 8'h04, 32'h28); energy_tick <= 1'b1; position_step <= 1'b1;
    repeat (3) @(posedge ref_clk);
    energy_tick <= 1'b0; position_step <= 1'b0;
    apb(0, 8'h2C, 0); check("energy_sum", rd, 32'h3);
    term(6'h01); apb(0, 8'h2C, 0); check("energy_clr", rd, 32'h0);
    apb(1, 8'h04, 32'h29); energy_tick <= 1'b1;
    repeat (2) @(posedge ref_clk);
    energy_tick <= 1'b0; apb(0, 8'h2C, 0); check("energy_hold", rd, 32'h0);
    apb(1, 8'h04, 32'h42); term(6'h00); term(6'h01);
    apb(0, 8'h30, 0); check("pos_clr", rd, 32'h0);
    term(6'h00);
  endtask
  task t_mode;
    drive_stopped <= 1'b0; apb(1, 8'h04, 32'h3C); term(6'h01);
    check("mode_running", {31'h0, control_mode}, 32'h0);
    drive_stopped <= 1'b1; term(6'h01); check("mode_vector", {31'h0, control_mode}, 32'h1);
    apb(1, 8'h04, 32'h3B); term(6'h01); check("mode_vf", {31'h0, control_mode}, 32'h0);
    term(6'h00);
  endtask
  task t_pol_fast;
    apb(1, 8'h20, 32'h01); apb(1, 8'h04, 32'h22); term(6'h00);
    check("pol_active", {31'h0, dc_brake}, 32'h1);
    apb(1, 8'h20, 32'h00); apb(1, 8'h04, 32'h00); apb(1, 8'h14, 32'h22); term(6'h10);
    check("fast_pulse", {31'h0, dc_brake}, 32'h0);
    apb(1, 8'h00, 32'h01); term(6'h10); check("fast_digital", {31'h0, dc_brake}, 32'h1);
    term(6'h00);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset(); t_levels(); t_source(); t_counts(); t_mode(); t_pol_fast(); t_pulse();
    stop_test();
  end
endmodule
`default_nettype wire
